// ---- rtl/asmp_host.sv ----
// Purpose: host controller driving an asynchronous 256K x 32 SRAM module
// Assumes: pin inputs synchronous to clk; one request at a time
// Notes: writes always float the module first by holding the output gate high
// Functional notes
// R1: Write strobe stays high for the whole read cycle.
// R2: Data is stored only while select and write strobe are both low.
// R3: Address changes only while select or write strobe is high.
// R4: Select never falls before write strobe, so module outputs stay floating.
// R5: Host drives data pins only after module outputs are off.
// R6: With gate low, strobe lasts max of pulse width or float plus overlap.
// R7: With gate high, strobe pulse may be the plain minimum width.
// R8: Recovery counts from the first rising strobe; zero ns required.
// R9: Address is valid no later than select falling in a read.
// R10: Deselected module is standby; reselect needs no power-up wait.
// R11: Four selects each gate one byte lane of the data word.
// R12: Module is asynchronous; read and write cycle lengths are equal.
// R13: Both depth id pins read ground for a 256K module.
// R14: Unselected lanes float and ignore the write strobe.
`timescale 1ns/1ps
module asmp_host
  import asmp_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [LANES-1:0] req_lanes,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic depth_ok,
  output logic standby,
  // Module pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic [LANES-1:0] mem_cs_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  input wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic [DATA_W-1:0] mem_dq_oe,
  input wire logic [1:0] depth_id_pins
);
  typedef enum {S_IDLE, S_RD_SEL, S_RD_WAIT, S_WR_STROBE, S_WR_SEL, S_WR_HOLD, S_RECOVER}
      asmp_state_t;
  asmp_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [LANES-1:0] lanes_q;
  logic [CNT_W-1:0] stby_q;
  logic drive_q;

  assign req_ready = (state_q == S_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      unique case (state_q)
        S_IDLE: begin
          cnt_q <= '0;
          if (req_valid) begin
            state_q <= req_write ? S_WR_STROBE : S_RD_SEL;
          end
        end
        S_RD_SEL: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(READ_CYC - 1)) begin
            state_q <= S_RD_WAIT;
          end
        end
        S_RD_WAIT: state_q <= S_RECOVER;
        // Strobe first, select one cycle later
        S_WR_STROBE: state_q <= S_WR_SEL; // R4
        S_WR_SEL: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(WP_PLAIN_CYC - 1)) begin // R6 R7
            state_q <= S_WR_HOLD;
          end
        end
        S_WR_HOLD: state_q <= S_RECOVER;
        S_RECOVER: state_q <= S_IDLE; // R8
      endcase
    end
  end

  // Address and lanes latched at request, stable for the whole cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr <= '0;
      lanes_q <= '0;
      mem_dq_o <= '0;
    end else if (ce && req_valid && state_q == S_IDLE) begin
      mem_addr <= req_addr; // R3 R9
      lanes_q <= req_lanes; // R11 R14
      mem_dq_o <= req_wdata;
    end
  end

  // Pin strobes registered, one concern each
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_cs_n <= '1;
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
      drive_q <= 1'b0;
    end else if (ce) begin
      mem_cs_n <= '1;
      mem_we_n <= 1'b1; // R1
      mem_oe_n <= 1'b1; // R7
      drive_q <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (req_valid && !req_write) begin
            mem_cs_n <= ~req_lanes; // R9 R10
            mem_oe_n <= 1'b0;
          end else if (req_valid) begin
            mem_we_n <= 1'b0; // R4
          end
        end
        S_RD_SEL: begin
          mem_cs_n <= ~lanes_q;
          mem_oe_n <= 1'b0;
        end
        S_WR_STROBE, S_WR_SEL: begin
          mem_we_n <= 1'b0;
          mem_cs_n <= ~lanes_q; // R2
          drive_q <= 1'b1; // R5
        end
        S_WR_HOLD: drive_q <= 1'b1; // R8
        default: ;
      endcase
    end
  end

  // Drive only selected lanes; gate was high so module is floating
  for (genvar i = 0; i < DATA_W; i++) begin : g_oe
    assign mem_dq_oe[i] = drive_q & lanes_q[i / 8]; // R5 R14
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (ce) begin
      rsp_valid <= (state_q == S_RD_WAIT) || (state_q == S_WR_HOLD); // R12
      if (state_q == S_RD_WAIT) begin
        rsp_rdata <= mem_dq_i;
      end
    end
  end

  // Standby indication after deselect time, cleared one cycle after reselect
  always_ff @(posedge clk) begin
    if (rst) begin
      stby_q <= '0;
      standby <= 1'b1;
    end else if (ce) begin
      if (mem_cs_n != '1) begin
        stby_q <= '0;
        standby <= 1'b0; // R10
      end else if (stby_q != CNT_W'(STBY_CYC)) begin
        stby_q <= stby_q + CNT_W'(1);
      end else begin
        standby <= 1'b1; // R10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      depth_ok <= 1'b0;
    end else if (ce) begin
      depth_ok <= (depth_id_pins == DEPTH_256K); // R13
    end
  end

  a_read_we_high: assert property (@(posedge clk) disable iff (rst) // R1
    (mem_oe_n == 1'b0) |-> mem_we_n)
    else $error("strobe low during read");
  a_addr_stable: assert property (@(posedge clk) disable iff (rst) // R3
    (!mem_we_n && mem_cs_n != '1) |=> $stable(mem_addr))
    else $error("address moved in write window");
  a_cs_after_we: assert property (@(posedge clk) disable iff (rst) // R4
    ($fell(mem_we_n)) |-> (mem_cs_n == '1))
    else $error("select fell before strobe");
  // Host drive only after a full cycle with the gate high
  a_no_contention: assert property (@(posedge clk) disable iff (rst) // R5
    (mem_dq_oe != '0) |-> (mem_oe_n && !$past(mem_oe_n == 1'b0)))
    else $error("host drives while module may drive");
  // Stepwise checks pause while ce is low, since frozen pins look like stalled steps
  sequence s_wr_win;
    !mem_we_n && mem_cs_n != '1;
  endsequence
  sequence s_sel_after_strobe;
    (mem_cs_n == '1) ##1 (mem_cs_n != '1);
  endsequence
  // Overlap of strobe and select spans two cycles, above both pulse minimums
  a_wr_pulse: assert property (@(posedge clk) disable iff (rst || !ce) // R6
    ($rose(!mem_we_n && mem_cs_n != '1)) |-> s_wr_win [*2])
    else $error("write window too short");
  a_select_order: assert property (@(posedge clk) disable iff (rst || !ce) // R2
    ($fell(mem_we_n)) |-> s_sel_after_strobe)
    else $error("select did not follow strobe");
  a_wr_float: assert property (@(posedge clk) disable iff (rst) // R7
    (!mem_we_n) |-> mem_oe_n)
    else $error("gate low during write");
  // Both strobes rise on one edge, so recovery starts there
  a_recover: assert property (@(posedge clk) disable iff (rst || !ce) // R8
    ($rose(mem_we_n)) |-> (mem_cs_n == '1))
    else $error("select held past strobe rise");
  a_read_addr_hold: assert property (@(posedge clk) disable iff (rst) // R9
    (mem_cs_n != '1 && !mem_oe_n) |=> ($stable(mem_addr) || mem_cs_n == '1))
    else $error("address moved during read");
  // Lane 1 stands for all lanes; a partial mask leaves it unselected
  a_lane_float: assert property (@(posedge clk) disable iff (rst) // R14
    (mem_dq_oe[15:8] != '0 && !mem_we_n) |-> !mem_cs_n[1])
    else $error("unselected lane driven");
endmodule

// ---- common/asmp_pkg.sv ----
// Purpose: constants for the host controller of a 256K x 32 asynchronous SRAM module
// Assumes: 20 MHz clock, slowest speed grade timing
// Notes: timing counts are derived from nanosecond figures
package asmp_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  // Slowest grade figures, in ns
  localparam int READ_CYCLE_NS = 45;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WE_TO_FLOAT_NS = 23;
  localparam int DATA_OVERLAP_MIN_NS = 25;
  localparam int WRITE_RECOVERY_NS = 0;
  localparam int DESELECT_TO_STANDBY_DELAY_NS = 45;
  // Least times round up to whole cycles, never below one; READ_CYC adds one cycle after rounding
  localparam int READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WP_PLAIN_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_GATED_NS = (WRITE_PULSE_NS > WE_TO_FLOAT_NS + DATA_OVERLAP_MIN_NS) ?
      WRITE_PULSE_NS : WE_TO_FLOAT_NS + DATA_OVERLAP_MIN_NS;
  localparam int WP_GATED_CYC = (WP_GATED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = 1;
  localparam int STBY_CYC = (DESELECT_TO_STANDBY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Expected level on the depth id pins for a 256K module
  localparam logic [1:0] DEPTH_256K = 2'h0;
endpackage

// ---- tb/asmp_sram_model.sv ----
// Purpose: behavioural 256K x 32 asynchronous SRAM module facing the host
// Assumes: pins sampled mid-cycle; host changes pins on rising edges
// Notes: err counts host timing faults; released lanes toggle, not hold
`timescale 1ns/1ps
module asmp_sram_model
  import asmp_pkg::*;
(
  // Pins
  input wire logic clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic [DATA_W-1:0] dq_oe,
  output logic [DATA_W-1:0] dq_i,
  output logic [1:0] depth_id_pins,
  // Fault count
  output int err
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] word;
  logic [ADDR_W-1:0] addr_q = '0;
  logic sel_q = 1'b0;
  logic win_q = 1'b0;
  logic win;
  int len = 0;
  assign depth_id_pins = DEPTH_256K;
  initial err = 0;
  initial dq_i = '0;
  always @(negedge clk) begin
    word = mem.exists(int'(addr)) ? mem[int'(addr)] : '0;
    win = ~&cs_n && !we_n;
    if (sel_q && ~&cs_n && addr !== addr_q) err++;
    if (win_q && !win && len < (oe_n ? WP_PLAIN_CYC : WP_GATED_CYC)) err++;
    for (int i = 0; i < LANES; i++) begin
      if (!cs_n[i] && !we_n) begin
        word[8*i+:8] = dq_o[8*i+:8];
        if (dq_oe[8*i+:8] !== 8'hFF) err++;
      end
      if (!cs_n[i] && we_n && !oe_n) begin
        if (|dq_oe[8*i+:8]) err++;
        dq_i[8*i+:8] = word[8*i+:8];
      end else dq_i[8*i+:8] = ~dq_i[8*i+:8];
    end
    if (win) mem[int'(addr)] = word;
    len = win ? len + 1 : 0;
    win_q = win;
    sel_q = ~&cs_n;
    addr_q = addr;
  end
endmodule

// ---- tb/test_asmp_host.sv ----
// Purpose: self-checking bench for the asynchronous SRAM host controller
// Assumes: one request at a time, clock enable dropped in one case only
// Notes: table rows first, then idle and mid-run reset cases
`timescale 1ns/1ps
module test_asmp_host;
  import asmp_pkg::*;
  typedef struct packed {
    logic w;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0] l;
    logic [DATA_W-1:0] e;
  } asmp_row_t;
  localparam asmp_row_t ROWS [7] = '{
    '{1'b1, 18'h00001, 32'hA5A55A5A, 4'hF, 32'h0},
    '{1'b0, 18'h00001, 32'h0, 4'hF, 32'hA5A55A5A},
    '{1'b1, 18'h00001, 32'h11223344, 4'h5, 32'h0},
    '{1'b0, 18'h00001, 32'h0, 4'hF, 32'hA5225A44},
    '{1'b1, 18'h3FFFF, 32'hDEADBEEF, 4'hF, 32'h0},
    '{1'b0, 18'h3FFFF, 32'h0, 4'hF, 32'hDEADBEEF},
    '{1'b0, 18'h00001, 32'h0, 4'hF, 32'hA5225A44}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [LANES-1:0] req_lanes = '0;
  logic req_ready, rsp_valid, depth_ok, standby, mem_we_n, mem_oe_n;
  logic [DATA_W-1:0] rsp_rdata, mem_dq_i, mem_dq_o, mem_dq_oe, got;
  logic [ADDR_W-1:0] mem_addr;
  logic [LANES-1:0] mem_cs_n;
  logic [1:0] depth_id_pins;
  int err, lat;
  int bad_count = 0;
  int cmp_count = 0;
  initial forever #25 clk = ~clk;
  asmp_host dut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .depth_ok(depth_ok), .standby(standby), .mem_addr(mem_addr),
    .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_i(mem_dq_i),
    .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .depth_id_pins(depth_id_pins));
  asmp_sram_model sram (.clk(clk), .addr(mem_addr), .cs_n(mem_cs_n), .we_n(mem_we_n),
    .oe_n(mem_oe_n), .dq_o(mem_dq_o), .dq_oe(mem_dq_oe), .dq_i(mem_dq_i),
    .depth_id_pins(depth_id_pins), .err(err));
  task automatic conclude();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_data(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_data({31'h0, g}, {31'h0, e});
  endtask
  task automatic xfer(input asmp_row_t r);
    int n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    {req_write, req_addr, req_wdata, req_lanes} <= {r.w, r.a, r.d, r.l};
    do @(negedge clk); while (req_ready !== 1'b1 && ++n < 20);
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do @(negedge clk); while (rsp_valid !== 1'b1 && ++lat < 40);
    if (n >= 20 || lat >= 40) begin
      bad_count++;
      conclude();
    end
    got = rsp_rdata;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(standby, 1'b1);
    chk_bit(depth_ok, 1'b1);
    foreach (ROWS[i]) begin
      xfer(ROWS[i]);
      chk_data(32'(lat), 32'h3);
      if (!ROWS[i].w) chk_data(got, ROWS[i].e);
      $display("Row %0d done", i);
    end
    repeat (3) @(negedge clk);
    chk_bit(standby, 1'b1);
    @(posedge clk);
    {req_valid, req_write, req_addr, req_lanes} <= {2'h3, 18'h00002, 4'hF};
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    req_valid <= 1'b0;
    repeat (2) @(negedge clk);
    chk_data({28'h0, mem_cs_n}, 32'hF);
    chk_data(mem_dq_oe, 32'h0);
    chk_bit(mem_we_n, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    xfer(ROWS[6]);
    chk_data(got, ROWS[6].e);
    // Two frozen edges in mid-read stretch the answer by two cycles
    fork
      xfer(ROWS[6]);
      begin
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(negedge clk);
        chk_bit(req_ready, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk_data(32'(lat), 32'h5);
    chk_data(got, ROWS[6].e);
    $display("Clock enable test done");
    chk_data(32'(err), 32'h0);
    $display("Reset test done");
    conclude();
  end
endmodule
